// ==== afe_ctrl.sv ====
/*
  Configuration and status logic of the converter analog front end:
  reference selection and monitor, level shift, burn-out and excitation
  current control, four shared pins and the modulator sample strobe.
  Assumes an Avalon-MM master on the register port, comparator outputs
  synchronous to clk and a conversion-start pulse from the sequencer.
*/
//
// Behaviour
// - Both reference codes 00 route the internal reference.
// - Both reference codes 01 route the analog supply pair.
// - Code 10 picks input pair 0/1, code 11 pair 2/3.
// - Positive and negative reference selectors are independent.
// - After reset both reference selectors hold the supply code.
// - One bit enables the internal reference; off after reset.
// - Reference below 0.4 V sets the low-reference alarm.
// - Alarm is read-only; clears at next conversion once condition gone.
// - Monitor watches the reference after the multiplexers.
// - Burn-out magnitude: off, 0.05, 0.2, 1, 10 microamps.
// - Pull-up sources positive, sinks negative; pull-down swaps.
// - Each excitation source has route and magnitude fields.
// - Connect bits attach each pin to its shared pad.
// - Direction bit 0 is output, 1 is input.
// - Pin data drives outputs when written, returns pins when read.
// - Output pins read back the written value, not the pad.
// - AC excitation overrides pin data on the pins.
// - Modulator samples at clock over eight.
// - Amplifier overload alarms are read-only status bits.
//
`include "afe_cfg.svh"

module afe_ctrl #(
  parameter int LS_T0_CYC = `AFE_LS_T0_US * `AFE_CLK_MHZ,
  parameter int LS_T1_CYC = `AFE_LS_T1_US * `AFE_CLK_MHZ,
  parameter int LS_T2_CYC = `AFE_LS_T2_US * `AFE_CLK_MHZ
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Avalon-MM slave
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // Conversion sequencer and comparators
  input  wire logic        conv_start,
  input  wire logic        ref_low_cmp,
  input  wire logic        amp_high_cmp,
  input  wire logic        amp_low_cmp,
  input  wire logic        mod_cmp_in,
  // Reference path
  output logic [1:0]       pos_ref_select,
  output logic [1:0]       neg_ref_select,
  output logic             intref_enable,
  output logic             intref_route,
  output logic             supply_route,
  output logic             ext_pair0_route,
  output logic             ext_pair1_route,
  // Level shift
  output logic             level_shift_voltage,
  output logic             level_shift_ready,
  // Burn-out currents
  output logic [2:0]       bo_level,
  output logic             bo_pos_source,
  output logic             bo_neg_source,
  // Excitation sources
  output logic [3:0]       exc_src1_route,
  output logic [3:0]       exc_src2_route,
  output logic [3:0]       exc_src1_level,
  output logic [3:0]       exc_src2_level,
  // Shared pins
  input  wire logic [3:0]  pin_in,
  input  wire logic [1:0]  acx_phase,
  output logic [3:0]       pin_out,
  output logic [3:0]       pin_oe,
  // Modulator
  output logic             mod_bit,
  output logic             mod_strobe,
  // Status
  output logic             ref_low_alarm,
  output logic             amp_overload_high_alarm,
  output logic             amp_overload_low_alarm
);

  ////////////////////////////////////////////////////////////////////////////
  // Decodes

  localparam logic [21:0] LS_C0 = 22'(LS_T0_CYC);
  localparam logic [21:0] LS_C1 = 22'(LS_T1_CYC);
  localparam logic [21:0] LS_C2 = 22'(LS_T2_CYC);
  localparam logic [2:0]  MOD_LAST = 3'(`AFE_MOD_DIV - 1);

  afe_pkg::afe_state_s st_ff;
  afe_pkg::afe_state_s nxt_st;

  logic        req;
  logic        acc_wr;
  logic [3:0]  pin_con;
  logic [3:0]  pin_dir;
  logic [3:0]  pin_dat;
  logic        acx_on;
  logic [3:0]  pin_rd;
  logic [21:0] ls_load;
  logic [3:0]  status_w;

  assign req     = avs_read | avs_write;
  // Write takes effect only at the edge where waitrequest is seen low
  assign acc_wr  = avs_write & (st_ff.bus_st == afe_pkg::AFE_ACK);
  assign pin_con = st_ff.gpio_r[3:0];
  assign pin_dir = st_ff.gpio_r[`AFE_GPIO_DIR_LSB +: 4];
  assign pin_dat = st_ff.gpio_r[`AFE_PIN_VALUE_BITS_LSB +: 4];
  assign acx_on  = st_ff.gpio_r[`AFE_GPIO_ACX];
  assign status_w = {st_ff.ls_rdy, st_ff.ampl_alm, st_ff.amph_alm, st_ff.ref_alm};

  always_comb begin
    case (avs_writedata[`AFE_REF_LSSEL +: 2])
      2'h0:    ls_load = LS_C0;
      2'h1:    ls_load = LS_C1;
      default: ls_load = LS_C2;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Shared pins: pads 2..5 alternate the two excitation phases

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_pin
      // AC excitation drives every connected pin whatever its direction
      assign pin_oe[gi]  = pin_con[gi] & (acx_on | ~pin_dir[gi]);
      assign pin_out[gi] = acx_on ? acx_phase[gi % 2] : pin_dat[gi];
      // Outputs read the stored value so a loaded pad cannot fake it
      assign pin_rd[gi]  = pin_dir[gi] ? pin_in[gi] : pin_dat[gi];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    nxt_st = st_ff;
    nxt_st.mod_stb = 1'b0;

    // Bus: one wait cycle, read data captured before the ack cycle
    case (st_ff.bus_st)
      afe_pkg::AFE_IDLE: begin
        if (req) begin
          nxt_st.bus_st = afe_pkg::AFE_ACK;
          case (avs_address)
            `AFE_OFS_REF:    nxt_st.rdata = {24'h00_0000, st_ff.ref_r};
            `AFE_OFS_BURN:   nxt_st.rdata = {28'h000_0000, st_ff.burn_r};
            `AFE_OFS_EXC:    nxt_st.rdata = {16'h0000, st_ff.exc_r};
            `AFE_OFS_GPIO:   nxt_st.rdata = {19'h0_0000, st_ff.gpio_r[12], pin_rd,
                                             st_ff.gpio_r[7:0]};
            `AFE_OFS_STATUS: nxt_st.rdata = {28'h000_0000, status_w};
            default:         nxt_st.rdata = 32'h0000_0000;
          endcase
        end
      end
      afe_pkg::AFE_ACK: nxt_st.bus_st = afe_pkg::AFE_IDLE;
      default:          nxt_st.bus_st = afe_pkg::AFE_IDLE;
    endcase

    if (acc_wr) begin
      case (avs_address)
        `AFE_OFS_REF:  nxt_st.ref_r  = avs_writedata[7:0];
        `AFE_OFS_BURN: nxt_st.burn_r = avs_writedata[3:0];
        `AFE_OFS_EXC:  nxt_st.exc_r  = avs_writedata[15:0];
        `AFE_OFS_GPIO: nxt_st.gpio_r = avs_writedata[12:0];
        default:       nxt_st.gpio_r = st_ff.gpio_r;
      endcase
    end

    // Level shift settle timer, restarted by every write that enables it
    if (acc_wr && avs_address == `AFE_OFS_REF) begin
      nxt_st.ls_rdy = 1'b0;
      nxt_st.ls_cnt = avs_writedata[`AFE_REF_LSH] ? ls_load : 22'h00_0000;
    end else if (!st_ff.ref_r[`AFE_REF_LSH]) begin
      nxt_st.ls_rdy = 1'b0;
    end else if (st_ff.ls_cnt != 22'h00_0000) begin
      nxt_st.ls_cnt = st_ff.ls_cnt - 22'h00_0001;
    end else begin
      nxt_st.ls_rdy = 1'b1;
    end

    // Alarms: set always wins, clear only at a conversion start
    if (ref_low_cmp) begin
      nxt_st.ref_alm = 1'b1;
    end else if (conv_start) begin
      nxt_st.ref_alm = 1'b0;
    end
    if (amp_high_cmp) begin
      nxt_st.amph_alm = 1'b1;
    end else if (conv_start) begin
      nxt_st.amph_alm = 1'b0;
    end
    if (amp_low_cmp) begin
      nxt_st.ampl_alm = 1'b1;
    end else if (conv_start) begin
      nxt_st.ampl_alm = 1'b0;
    end

    // Modulator sample strobe at clk / 8
    if (st_ff.mod_cnt == MOD_LAST) begin
      nxt_st.mod_cnt = 3'h0;
      nxt_st.mod_bit = mod_cmp_in;
      nxt_st.mod_stb = 1'b1;
    end else begin
      nxt_st.mod_cnt = st_ff.mod_cnt + 3'h1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_ff          <= '0;
      st_ff.ref_r    <= `AFE_REF_RST;
      st_ff.burn_r   <= `AFE_BURN_RST;
      st_ff.exc_r    <= `AFE_EXC_RST;
      st_ff.gpio_r   <= `AFE_GPIO_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign avs_waitrequest = req & (st_ff.bus_st != afe_pkg::AFE_ACK);
  assign avs_readdata    = st_ff.rdata;

  assign pos_ref_select  = st_ff.ref_r[`AFE_REF_POS_LSB +: 2];
  assign neg_ref_select  = st_ff.ref_r[`AFE_REF_NEG_LSB +: 2];
  assign intref_enable   = st_ff.ref_r[`AFE_REF_INTREF];
  assign intref_route    = (pos_ref_select == 2'h0) & (neg_ref_select == 2'h0);
  assign supply_route    = (pos_ref_select == 2'h1) & (neg_ref_select == 2'h1);
  assign ext_pair0_route = (pos_ref_select == 2'h2) & (neg_ref_select == 2'h2);
  assign ext_pair1_route = (pos_ref_select == 2'h3) & (neg_ref_select == 2'h3);

  assign level_shift_voltage = st_ff.ref_r[`AFE_REF_LSH];
  assign level_shift_ready   = st_ff.ls_rdy;

  // Codes above 4 are unused and park the currents off
  assign bo_level      = (st_ff.burn_r[2:0] > 3'h4) ? 3'h0 : st_ff.burn_r[2:0];
  assign bo_pos_source = ~st_ff.burn_r[`AFE_BURN_PULLDN];
  assign bo_neg_source = st_ff.burn_r[`AFE_BURN_PULLDN];

  assign exc_src1_route = st_ff.exc_r[3:0];
  assign exc_src2_route = st_ff.exc_r[7:4];
  assign exc_src1_level = st_ff.exc_r[11:8];
  assign exc_src2_level = st_ff.exc_r[15:12];

  assign mod_bit    = st_ff.mod_bit;
  assign mod_strobe = st_ff.mod_stb;

  assign ref_low_alarm           = st_ff.ref_alm;
  assign amp_overload_high_alarm = st_ff.amph_alm;
  assign amp_overload_low_alarm  = st_ff.ampl_alm;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  logic wr_ref;
  assign wr_ref = acc_wr & (avs_address == `AFE_OFS_REF);

  a_ref_internal: assert property (@(posedge clk) disable iff (!nrst)
    wr_ref && avs_writedata[3:0] == 4'h0 |=> intref_route && !supply_route)
    else $error("internal reference not routed");

  a_ref_supply: assert property (@(posedge clk) disable iff (!nrst)
    wr_ref && avs_writedata[3:0] == 4'h5 |=> supply_route && !intref_route)
    else $error("supply reference not routed");

  a_ref_external: assert property (@(posedge clk) disable iff (!nrst)
    wr_ref && avs_writedata[3:0] == 4'ha |=> ext_pair0_route && !ext_pair1_route)
    else $error("external pair not routed");

  a_ref_reset: assert property (@(posedge clk)
    $rose(nrst) |-> supply_route && !intref_enable)
    else $error("reset reference not supply");

  a_alarm_set: assert property (@(posedge clk) disable iff (!nrst)
    ref_low_cmp |=> ref_low_alarm)
    else $error("low reference not flagged");

  a_alarm_hold: assert property (@(posedge clk) disable iff (!nrst)
    ref_low_alarm && !conv_start |=> ref_low_alarm)
    else $error("alarm dropped between conversions");

  a_alarm_clear: assert property (@(posedge clk) disable iff (!nrst)
    ref_low_alarm && conv_start && !ref_low_cmp |=> !ref_low_alarm)
    else $error("alarm not cleared at conversion");

  a_amp_alarm: assert property (@(posedge clk) disable iff (!nrst)
    amp_high_cmp ##1 !conv_start |=> amp_overload_high_alarm)
    else $error("overload alarm lost");

  a_mod_rate: assert property (@(posedge clk) disable iff (!nrst)
    mod_strobe |=> !mod_strobe [*7] ##1 mod_strobe)
    else $error("modulator strobe not every eight clocks");

  a_pin_override: assert property (@(posedge clk) disable iff (!nrst)
    acx_on && pin_con[1] |-> pin_oe[1] && pin_out[1] == acx_phase[1])
    else $error("excitation does not own pin");

  a_pin_readback: assert property (@(posedge clk) disable iff (!nrst)
    avs_read && avs_address == `AFE_OFS_GPIO && st_ff.bus_st == afe_pkg::AFE_IDLE
    && !pin_dir[3]
    |=> avs_readdata[11] == $past(pin_dat[3]))
    else $error("output pin read back from pad");

  a_burn_swap: assert property (@(posedge clk) disable iff (!nrst)
    acc_wr && avs_address == `AFE_OFS_BURN |=> bo_pos_source != $past(avs_writedata[3]))
    else $error("burn-out polarity wrong");

  // Register fields reach their outputs one cycle after the accepted write
  a_ref_pair1: assert property (@(posedge clk) disable iff (!nrst)
    wr_ref && avs_writedata[3:0] == 4'hf |=> ext_pair1_route && !ext_pair0_route)
    else $error("second external pair not routed");

  a_ref_indep: assert property (@(posedge clk) disable iff (!nrst)
    wr_ref |=> pos_ref_select == $past(avs_writedata[1:0]) && neg_ref_select == $past(avs_writedata[3:2]))
    else $error("reference selectors not independent");

  a_intref_bit: assert property (@(posedge clk) disable iff (!nrst)
    wr_ref |=> intref_enable == $past(avs_writedata[`AFE_REF_INTREF]))
    else $error("internal reference enable not taken");

  a_amp_low: assert property (@(posedge clk) disable iff (!nrst)
    amp_low_cmp |=> amp_overload_low_alarm)
    else $error("low overload alarm lost");

  a_alarm_stable: assert property (@(posedge clk) disable iff (!nrst)
    !conv_start && !ref_low_cmp |=> $stable(ref_low_alarm))
    else $error("alarm changed between conversions");

  a_burn_level: assert property (@(posedge clk) disable iff (!nrst)
    acc_wr && avs_address == `AFE_OFS_BURN && avs_writedata[2:0] <= 3'h4
    |=> bo_level == $past(avs_writedata[2:0]))
    else $error("burn-out level not applied");

  a_burn_unused: assert property (@(posedge clk) disable iff (!nrst)
    acc_wr && avs_address == `AFE_OFS_BURN && avs_writedata[2:0] > 3'h4 |=> bo_level == 3'h0)
    else $error("unused burn-out code not parked");

  a_exc_fields: assert property (@(posedge clk) disable iff (!nrst)
    acc_wr && avs_address == `AFE_OFS_EXC
    |=> {exc_src2_level, exc_src1_level, exc_src2_route, exc_src1_route} == $past(avs_writedata[15:0]))
    else $error("excitation fields not applied");

  a_ls_restart: assert property (@(posedge clk) disable iff (!nrst)
    wr_ref |=> !level_shift_ready)
    else $error("settle flag kept across reference write");

  a_ls_off: assert property (@(posedge clk) disable iff (!nrst)
    !level_shift_voltage |=> !level_shift_ready)
    else $error("settle flag without level shift");

  a_mod_bit: assert property (@(posedge clk) disable iff (!nrst)
    mod_strobe |-> mod_bit == $past(mod_cmp_in))
    else $error("modulator bit not sampled at strobe");

  a_pin_connect: assert property (@(posedge clk) disable iff (!nrst)
    pin_con == 4'h0 |-> pin_oe == 4'h0)
    else $error("unconnected pin driven");

  a_pin_input: assert property (@(posedge clk) disable iff (!nrst)
    !acx_on && pin_dir == 4'hf |-> pin_oe == 4'h0)
    else $error("input pin driven");

  a_pin_data: assert property (@(posedge clk) disable iff (!nrst)
    !acx_on |-> pin_out == pin_dat)
    else $error("pin data not driven");

  a_acx_even: assert property (@(posedge clk) disable iff (!nrst)
    acx_on && pin_con[2] |-> pin_oe[2] && pin_out[2] == acx_phase[0])
    else $error("excitation does not own even pin");

endmodule // afe_ctrl

// ==== afe_cfg.svh ====
/*
  Offsets, field positions, reset values and timing figures of the
  front-end control block. Assumes a 125 MHz core clock.
*/
`ifndef AFE_CFG_SVH
`define AFE_CFG_SVH

// Register byte offsets
`define AFE_OFS_REF      5'h00
`define AFE_OFS_BURN     5'h04
`define AFE_OFS_EXC      5'h08
`define AFE_OFS_GPIO     5'h0c
`define AFE_OFS_STATUS   5'h10

// Reference register fields
`define AFE_REF_POS_LSB  0
`define AFE_REF_NEG_LSB  2
`define AFE_REF_INTREF   4
`define AFE_REF_LSH      5
`define AFE_REF_LSSEL    6
`define AFE_REF_RST      8'h05

// Burn-out register fields
`define AFE_BURN_PULLDN  3
`define AFE_BURN_RST     4'h0

// Excitation register reset: both routes parked, both levels off
`define AFE_EXC_RST      16'h00ff

// Pin register fields
`define AFE_GPIO_DIR_LSB 4
`define AFE_PIN_VALUE_BITS_LSB 8
`define AFE_GPIO_ACX     12
`define AFE_GPIO_RST     13'h00f0

// Timing
`define AFE_CLK_MHZ      125
`define AFE_MOD_DIV      8
`define AFE_LS_T0_US     220
`define AFE_LS_T1_US     2200
`define AFE_LS_T2_US     22000

`endif

// ==== afe_pkg.sv ====
/*
  Types of the front-end control block.
  Assumes afe_cfg.svh sits in the include path.
*/
package afe_pkg;

  typedef enum logic {
    AFE_IDLE,
    AFE_ACK
  } afe_bus_e;

  typedef struct packed {
    afe_bus_e    bus_st;
    logic [31:0] rdata;
    logic [7:0]  ref_r;
    logic [3:0]  burn_r;
    logic [15:0] exc_r;
    logic [12:0] gpio_r;
    logic        ref_alm;
    logic        amph_alm;
    logic        ampl_alm;
    logic [21:0] ls_cnt;
    logic        ls_rdy;
    logic [2:0]  mod_cnt;
    logic        mod_bit;
    logic        mod_stb;
  } afe_state_s;

endpackage

// ==== afe_env.sv ====
/*
  Analog side model of the front end: reference comparator placed after
  the reference muxes, and the four shared pads.
  Assumes the bench sets which reference sources are low and pad levels.
*/
module afe_env (
  // Reference path
  input  wire logic [1:0] pos_ref_select,
  input  wire logic [1:0] neg_ref_select,
  input  wire logic [3:0] src_low,
  output logic            ref_low_cmp,
  // Shared pads
  input  wire logic [3:0] pin_out,
  input  wire logic [3:0] pin_oe,
  input  wire logic [3:0] pad_ext,
  output logic [3:0]      pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  ////////////////////////////////////////
  // Only the selected pair reaches the comparator
  assign ref_low_cmp = src_low[pos_ref_select] | src_low[neg_ref_select];
  // Driven pads follow the block, others the outside level
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & pad_ext);
endmodule // afe_env

// ==== tb.sv ====
/*
  Self-checking bench of afe_ctrl with the analog side model afe_env.
  Assumes afe_cfg.svh in the include path and an Avalon-MM host.
*/
`include "afe_cfg.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, nrst = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
  logic        conv_start = 1'b0, amp_high_cmp = 1'b0, amp_low_cmp = 1'b0, mod_cmp_in = 1'b0;
  logic [4:0]  avs_address = 5'h00;
  logic [31:0] avs_writedata = 32'h0000_0000, avs_readdata;
  logic [3:0]  src_low = 4'h0, pad_ext = 4'h0, pin_in, pin_out, pin_oe;
  logic [1:0]  acx_phase = 2'h0, pos_ref_select, neg_ref_select;
  logic        avs_waitrequest, ref_low_cmp, intref_enable, intref_route, supply_route;
  logic        ext_pair0_route, ext_pair1_route, level_shift_voltage, level_shift_ready;
  logic        bo_pos_source, bo_neg_source, mod_bit, mod_strobe;
  logic        ref_low_alarm, amp_overload_high_alarm, amp_overload_low_alarm;
  logic [2:0]  bo_level;
  logic [3:0]  exc_src1_route, exc_src2_route, exc_src1_level, exc_src2_level;
  int          err_count = 0, n_compared = 0, n;
  localparam int LS_CYC [3] = '{20, 40, 60};

  afe_ctrl #(.LS_T0_CYC(20), .LS_T1_CYC(40), .LS_T2_CYC(60)) i_afe_ctrl (
    .clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata,
    .avs_waitrequest, .conv_start, .ref_low_cmp, .amp_high_cmp, .amp_low_cmp, .mod_cmp_in,
    .pos_ref_select, .neg_ref_select, .intref_enable, .intref_route, .supply_route,
    .ext_pair0_route, .ext_pair1_route, .level_shift_voltage, .level_shift_ready,
    .bo_level, .bo_pos_source, .bo_neg_source, .exc_src1_route, .exc_src2_route,
    .exc_src1_level, .exc_src2_level, .pin_in, .acx_phase, .pin_out, .pin_oe, .mod_bit,
    .mod_strobe, .ref_low_alarm, .amp_overload_high_alarm, .amp_overload_low_alarm);
  afe_env i_afe_env (.pos_ref_select, .neg_ref_select, .src_low, .ref_low_cmp,
    .pin_out, .pin_oe, .pad_ext, .pin_in);

  always #4 clk = ~clk;
  ////////////////////////////////////////
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic tmo(input int cnt);
    if (cnt >= 100) begin
      chk("wait_bound", 32'(cnt), 32'h0000_0000);
      print_verdict;
    end
  endtask
  // One idle edge first, so a strobe is never assigned twice in one step
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    int k;
    k = 0;
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    do begin
      @(posedge clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 100);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    tmo(k);
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input string nm, input logic [4:0] a, input logic [31:0] e);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, q);
    chk(nm, q, e);
  endtask
  task automatic pulse;
    @(posedge clk);
    conv_start <= 1'b1;
    @(posedge clk);
    conv_start <= 1'b0;
    @(negedge clk);
  endtask
  task automatic wait_hi(ref logic s);
    do begin
      @(posedge clk);
      n++;
      @(negedge clk);
    end while (s !== 1'b1 && n < 100);
    tmo(n);
  endtask
  ////////////////////////////////////////
  task automatic t_reset;
    chk("rst_ref", {intref_enable, supply_route, pos_ref_select, neg_ref_select}, 6'h15);
    chk("rst_oe", pin_oe, 4'h0);
    rd("ref", `AFE_OFS_REF, 32'h0000_0005);
    rd("burn", `AFE_OFS_BURN, 32'h0000_0000);
    rd("exc", `AFE_OFS_EXC, 32'h0000_00ff);
    rd("gpio", `AFE_OFS_GPIO, 32'h0000_00f0);
    rd("status", `AFE_OFS_STATUS, 32'h0000_0000);
    wr(5'h14, 32'hffff_ffff);
    rd("unmapped", 5'h14, 32'h0000_0000);
    $display("t_reset done");
  endtask
  task automatic t_refsel;
    for (int c = 0; c < 4; c++) begin
      wr(`AFE_OFS_REF, 32'(c * 5));
      @(negedge clk);
      chk("route", {intref_route, supply_route, ext_pair0_route, ext_pair1_route}, 4'h8 >> c);
      chk("sel", {pos_ref_select, neg_ref_select}, 32'(c * 5));
    end
    wr(`AFE_OFS_REF, 32'h0000_000e);
    @(negedge clk);
    chk("mix_sel", {pos_ref_select, neg_ref_select}, 4'hb);
    chk("mix_route", {intref_route, supply_route, ext_pair0_route, ext_pair1_route}, 4'h0);
    $display("t_refsel done");
  endtask
  task automatic t_alarm;
    wr(`AFE_OFS_REF, 32'h0000_0005);
    src_low <= 4'h4;
    pulse;
    chk("alm_unsel", ref_low_alarm, 1'b0);
    wr(`AFE_OFS_REF, 32'h0000_000a);
    repeat (2) @(negedge clk);
    chk("alm_set", ref_low_alarm, 1'b1);
    wr(`AFE_OFS_STATUS, 32'h0000_0000);
    src_low <= 4'h0;
    rd("alm_hold", `AFE_OFS_STATUS, 32'h0000_0001);
    pulse;
    chk("alm_clr", ref_low_alarm, 1'b0);
    @(posedge clk);
    amp_high_cmp <= 1'b1;
    amp_low_cmp  <= 1'b1;
    @(posedge clk);
    amp_high_cmp <= 1'b0;
    amp_low_cmp  <= 1'b0;
    rd("amp_status", `AFE_OFS_STATUS, 32'h0000_0006);
    pulse;
    chk("amp_clr", {amp_overload_high_alarm, amp_overload_low_alarm}, 2'h0);
    $display("t_alarm done");
  endtask
  task automatic t_burn;
    for (int i = 0; i < 16; i++) begin
      wr(`AFE_OFS_BURN, 32'(i));
      @(negedge clk);
      chk("bo_level", bo_level, (i % 8) < 5 ? 32'(i % 8) : 32'h0000_0000);
      chk("bo_dir", {bo_pos_source, bo_neg_source}, i > 7 ? 2'h1 : 2'h2);
    end
    $display("t_burn done");
  endtask
  task automatic t_exc;
    wr(`AFE_OFS_REF, 32'h0000_0015);
    @(negedge clk);
    chk("intref_on", intref_enable, 1'b1);
    wr(`AFE_OFS_EXC, 32'h0000_3a52);
    @(negedge clk);
    chk("exc_out", {exc_src2_level, exc_src1_level, exc_src2_route, exc_src1_route}, 16'h3a52);
    rd("exc_rb", `AFE_OFS_EXC, 32'h0000_3a52);
    $display("t_exc done");
  endtask
  // Pin 3 is an unconnected output, so its pad disagrees with its data
  task automatic t_gpio;
    wr(`AFE_OFS_GPIO, 32'h0000_0a37);
    pad_ext <= 4'h5;
    @(negedge clk);
    chk("oe", pin_oe, 4'h4);
    chk("out2_lo", pin_out[2], 1'b0);
    rd("gpio_rb", `AFE_OFS_GPIO, 32'h0000_0937);
    wr(`AFE_OFS_GPIO, 32'h0000_0e37);
    @(negedge clk);
    chk("out2_hi", pin_out[2], 1'b1);
    wr(`AFE_OFS_GPIO, 32'h0000_1a37);
    acx_phase <= 2'h2;
    @(negedge clk);
    chk("acx_oe", pin_oe, 4'h7);
    chk("acx_a", pin_out, 4'ha);
    @(posedge clk);
    acx_phase <= 2'h1;
    @(negedge clk);
    chk("acx_b", pin_out, 4'h5);
    wr(`AFE_OFS_GPIO, 32'h0000_00f0);
    $display("t_gpio done");
  endtask
  task automatic t_lshift;
    for (int s = 0; s < 3; s++) begin
      wr(`AFE_OFS_REF, 32'h0000_0025 | 32'(s << 6));
      @(negedge clk);
      chk("ls_on", level_shift_voltage, 1'b1);
      n = 0;
      wait_hi(level_shift_ready);
      chk("settle", 32'(n), 32'(LS_CYC[s] + 1));
      rd("ls_status", `AFE_OFS_STATUS, 32'h0000_0008);
      // Host starts converting only once settled
      pulse;
    end
    wr(`AFE_OFS_REF, 32'h0000_0005);
    @(negedge clk);
    chk("ls_off", {level_shift_voltage, level_shift_ready}, 2'h0);
    $display("t_lshift done");
  endtask
  task automatic t_mod;
    n = 0;
    wait_hi(mod_strobe);
    for (int v = 1; v >= 0; v--) begin
      @(posedge clk);
      mod_cmp_in <= v[0];
      n = 1;
      @(negedge clk);
      wait_hi(mod_strobe);
      chk("mod_period", 32'(n), 32'h0000_0008);
      chk("mod_bit", mod_bit, v[0]);
    end
    $display("t_mod done");
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    t_reset;
    t_refsel;
    t_alarm;
    t_burn;
    t_exc;
    t_gpio;
    t_lshift;
    t_mod;
    print_verdict;
  end
endmodule // tb
